// ==== rtl/ofsb_overflow_bank.sv ====
// ofsb_overflow_bank: sticky input fifo overflow flags for 128 channels plus summary
// assumes: fifo write and full strobes come from logic on pclk, apb master on pclk
`timescale 1ns/1ps
`default_nettype none

module ofsb_overflow_bank #(
  parameter int NUM_CH = ofsb_pkg::NUM_CH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ofsb_pkg::ADDR_W-1:0] paddr,
  input wire logic [ofsb_pkg::REG_W-1:0] pwdata,
  output logic [ofsb_pkg::REG_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] fifo_wr,
  input wire logic [NUM_CH-1:0] fifo_full
);

  localparam int NREG = NUM_CH / ofsb_pkg::REG_W;
  localparam int IW = ofsb_pkg::IDX_W;

  ofsb_pkg::ofsb_req_s req;
  logic [ofsb_pkg::IDX_W-1:0] setup_idx;
  logic [ofsb_pkg::REG_W-1:0] rd_word;
  logic [NUM_CH-1:0] ovf_evt;
  logic [NUM_CH-1:0] flags;
  logic [NREG-1:0] clr;
  logic [ofsb_pkg::REG_W-1:0] summary;
  logic unused_wdata;

  // write data carries no meaning: any write clears the whole word
  assign unused_wdata = ^pwdata;

  // overflow is a write attempted into a full fifo
  assign ovf_evt = fifo_wr & fifo_full;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_word
      // word g holds channels 32g+1 .. 32g+32, bit k is channel 32g+k+1
      assign clr[g] = req.take_wr &&
        (req.idx == ofsb_pkg::IDX_FLAGS_CH1_32 + IW'(g));
      ofsb_sticky_word #(
        .W(ofsb_pkg::REG_W)
      ) u_word (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .set_evt(ovf_evt[g*ofsb_pkg::REG_W +: ofsb_pkg::REG_W]),
        .clear(clr[g]),
        .q(flags[g*ofsb_pkg::REG_W +: ofsb_pkg::REG_W])
      );
      assign summary[ofsb_pkg::SUM_GROUP1_BIT + g] =
        |flags[g*ofsb_pkg::REG_W +: ofsb_pkg::REG_W];
    end
  endgenerate

  // group 5 (channels 129-160) lives outside this bank and reads as zero here
  assign summary[ofsb_pkg::REG_W-1:ofsb_pkg::SUM_GROUP1_BIT+NREG] = '0;

  always_comb begin
    case (setup_idx)
      ofsb_pkg::IDX_SUMMARY: rd_word = summary;
      ofsb_pkg::IDX_FLAGS_CH1_32: rd_word = flags[31:0];
      ofsb_pkg::IDX_FLAGS_CH33_64: rd_word = flags[63:32];
      ofsb_pkg::IDX_FLAGS_CH65_96: rd_word = flags[95:64];
      ofsb_pkg::IDX_FLAGS_CH97_128: rd_word = flags[127:96];
      default: rd_word = ofsb_pkg::UNMAPPED_READ;
    endcase
  end

  ofsb_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rd_word(rd_word),
    .req(req),
    .setup_idx(setup_idx),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence ovf_s(int ch);
    clk_en && fifo_wr[ch] && fifo_full[ch];
  endsequence

  sequence wr_clear_s(logic [ofsb_pkg::IDX_W-1:0] ix);
    psel && penable && pwrite && clk_en && (paddr[ofsb_pkg::ADDR_W-1:2] == ix)
      && (paddr[1:0] == 2'h0);
  endsequence

  sequence rd_setup_s(logic [ofsb_pkg::IDX_W-1:0] ix);
    psel && !penable && !pwrite && clk_en && (paddr == {ix, 2'h0});
  endsequence

  flag_sticky_a: assert property (
    (flags != '0) && !req.take_wr && clk_en |=> (flags & $past(flags)) == $past(flags))
    else $error("overflow flag dropped without a clearing write");

  frozen_hold_a: assert property (
    !clk_en |=> flags == $past(flags))
    else $error("flags changed while clock enable was low");

  ch1_bit_a: assert property (
    ovf_s(0) ##1 !req.take_wr ##1 rd_setup_s(ofsb_pkg::IDX_FLAGS_CH1_32)
      |-> flags[0] ##1 prdata[0])
    else $error("channel 1 overflow not reported in bit 0");

  ch64_bit_a: assert property (
    ovf_s(63) ##1 !req.take_wr ##1 rd_setup_s(ofsb_pkg::IDX_FLAGS_CH33_64) |=> prdata[31])
    else $error("channel 64 overflow not in second word bit 31");

  ch33_bit_a: assert property (
    ovf_s(32) ##1 !req.take_wr ##1 rd_setup_s(ofsb_pkg::IDX_FLAGS_CH33_64) |=> prdata[0])
    else $error("channel 33 overflow not in second word bit 0");

  ch72_bit_a: assert property (
    ovf_s(71) ##1 !req.take_wr ##1 rd_setup_s(ofsb_pkg::IDX_FLAGS_CH65_96) |=> prdata[7])
    else $error("channel 72 overflow not in third word bit 7");

  ch128_bit_a: assert property (
    ovf_s(127) ##1 !req.take_wr ##1 rd_setup_s(ofsb_pkg::IDX_FLAGS_CH97_128) |=> prdata[31])
    else $error("channel 128 overflow not in fourth word bit 31");

  ch107_bit_a: assert property (
    ovf_s(106) ##1 !req.take_wr ##1 rd_setup_s(ofsb_pkg::IDX_FLAGS_CH97_128)
      |=> prdata[10] && (prdata[9] == $past(flags[105])))
    else $error("channel 107 overflow not in fourth word bit 10 only");

  word_clear_a: assert property (
    wr_clear_s(ofsb_pkg::IDX_FLAGS_CH65_96) ##0 (ovf_evt[95:64] == '0)
      |=> flags[95:64] == '0 ##0 $stable(flags[31:0]) || $past(ovf_evt[31:0]) != '0)
    else $error("write to third word did not clear it alone");

  word2_clear_a: assert property (
    wr_clear_s(ofsb_pkg::IDX_FLAGS_CH33_64) ##0 (ovf_evt[63:32] == '0)
      |=> flags[63:32] == '0)
    else $error("write to second word did not clear it");

  word4_clear_a: assert property (
    wr_clear_s(ofsb_pkg::IDX_FLAGS_CH97_128) ##0 (ovf_evt[127:96] == '0)
      |=> flags[127:96] == '0)
    else $error("write to fourth word did not clear it");

  // the summary is derived, so a write to it must leave every flag alone
  summary_keep_a: assert property (
    wr_clear_s(ofsb_pkg::IDX_SUMMARY) |=> flags == ($past(flags) | $past(ovf_evt)))
    else $error("write to the summary register changed the flags");

  set_wins_a: assert property (
    wr_clear_s(ofsb_pkg::IDX_FLAGS_CH1_32) ##0 ovf_s(5) |=> flags[5])
    else $error("overflow lost in the clearing cycle");

  summary_rd_a: assert property (
    rd_setup_s(ofsb_pkg::IDX_SUMMARY) |=> prdata[ofsb_pkg::SUM_GROUP1_BIT] == $past(|flags[31:0])
      && !prdata[ofsb_pkg::SUM_GROUP5_BIT])
    else $error("summary bit 0 disagrees with channels 1-32");

  summary_grp_a: assert property (
    rd_setup_s(ofsb_pkg::IDX_SUMMARY) |=> prdata[3:1] ==
      $past({|flags[127:96], |flags[95:64], |flags[63:32]}))
    else $error("group summary bits wrong");

  overflow_set_a: assert property (
    ovf_s(40) ##1 (!req.take_wr) [*2] |-> flags[40])
    else $error("overflow did not set its flag");

  reset_zero_a: assert property (@(posedge pclk) disable iff (1'b0)
    !presetn |-> flags == '0 && prdata == '0)
    else $error("flags or read data not zero under reset");

  unmapped_err_a: assert property (
    psel && penable && clk_en && !ofsb_pkg::ofsb_is_mapped(paddr) |-> pslverr && pready
      ##1 flags == ($past(flags) | $past(ovf_evt)))
    else $error("unmapped access not refused cleanly");

endmodule // ofsb_overflow_bank

`default_nettype wire

// ==== pkg/ofsb_pkg.sv ====
// ofsb_pkg: constants, register map and carrier types of the overflow status bank
// assumes: single pclk domain, apb3 slave with 32-bit data and word-aligned registers
//
// Operation
// - per-channel overflow flag stays set after the event until software clears it
// - first status register holds channels 1-32, bit k is channel k+1
// - second status register holds channels 33-64, bit 0 is 33, bit 31 is 64
// - third status register holds channels 65-96, bit k is 65+k, bit 7 is 72
// - fourth status register holds channels 97-128, bit k is 97+k, bit 31 is 128
// - fourth register bit 10 reports channel 107
// - any write to a status register clears its latched flags
// - summary bit 0 is set while any flag of channels 1-32 is set
// - summary carries one bit per 32-channel group, up to bit 4 for 129-160; this bank always reads bit 4 as zero

package ofsb_pkg;

  localparam int NUM_CH = 128;
  localparam int REG_W = 32;
  localparam int NUM_REGS = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SUMMARY = 10'h0D9;
  localparam logic [IDX_W-1:0] IDX_FLAGS_CH1_32 = 10'h0DA;
  localparam logic [IDX_W-1:0] IDX_FLAGS_CH33_64 = 10'h0DB;
  localparam logic [IDX_W-1:0] IDX_FLAGS_CH65_96 = 10'h0DC;
  localparam logic [IDX_W-1:0] IDX_FLAGS_CH97_128 = 10'h0DD;

  localparam logic [REG_W-1:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [REG_W-1:0] SUMMARY_RESET = 32'h0000_0000;
  localparam logic [REG_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  localparam int SUM_GROUP1_BIT = 0;
  localparam int SUM_GROUP5_BIT = 4;

  // one taken apb transfer, valid for the access edge only
  typedef struct packed {
    logic take_wr;
    logic take_rd;
    logic [IDX_W-1:0] idx;
  } ofsb_req_s;

  function automatic logic ofsb_is_mapped(input logic [ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    idx = addr[ADDR_W-1:2];
    return (addr[1:0] == 2'h0) && (idx >= IDX_SUMMARY) && (idx <= IDX_FLAGS_CH97_128);
  endfunction

endpackage

// ==== rtl/ofsb_sticky_word.sv ====
// ofsb_sticky_word: one word of sticky event flags, cleared as a whole
// assumes: set and clear come from logic on pclk
`timescale 1ns/1ps
`default_nettype none

module ofsb_sticky_word #(
  parameter int W = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [W-1:0] set_evt,
  input wire logic clear,
  output logic [W-1:0] q
);

  // set beats clear so an overflow in the clearing cycle is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= W'(ofsb_pkg::FLAGS_RESET);
    end else if (clk_en) begin
      q <= (clear ? '0 : q) | set_evt;
    end
  end

endmodule // ofsb_sticky_word

`default_nettype wire

// ==== rtl/ofsb_apb_slave.sv ====
// ofsb_apb_slave: apb3 handshake, decode and registered read data
// assumes: read word is supplied combinationally for the index in setup
`timescale 1ns/1ps
`default_nettype none

module ofsb_apb_slave (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ofsb_pkg::ADDR_W-1:0] paddr,
  input wire logic [ofsb_pkg::REG_W-1:0] rd_word,
  output ofsb_pkg::ofsb_req_s req,
  output logic [ofsb_pkg::IDX_W-1:0] setup_idx,
  output logic [ofsb_pkg::REG_W-1:0] prdata,
  output logic pready,
  output logic pslverr
);

  logic hit;
  logic access;

  assign hit = ofsb_pkg::ofsb_is_mapped(paddr);
  assign access = psel && penable;
  assign setup_idx = paddr[ofsb_pkg::ADDR_W-1:2];
  // a frozen block cannot complete a transfer
  assign pready = clk_en;
  assign pslverr = access && !hit;

  always_comb begin
    req.take_wr = access && pready && pwrite && hit;
    req.take_rd = access && pready && !pwrite && hit;
    req.idx = setup_idx;
  end

  // read data captured at the setup edge, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ofsb_pkg::UNMAPPED_READ;
    end else if (clk_en && psel && !penable) begin
      prdata <= (!pwrite && hit) ? rd_word : ofsb_pkg::UNMAPPED_READ;
    end
  end

endmodule // ofsb_apb_slave

`default_nettype wire

// ==== dv/ofsb_overflow_bank_tb.sv ====
// ofsb_overflow_bank_tb: self-checking bench for the overflow status bank
// assumes: package and design compiled first; the assertions live in the design files
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module ofsb_overflow_bank_tb;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rng;
  logic [127:0] fifo_wr, fifo_full;
  logic [31:0] exp_w [4];
  int failures, n_checks;
  int chans [9] = '{1, 32, 33, 64, 65, 72, 97, 107, 128};

  ofsb_overflow_bank dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_wr(fifo_wr), .fifo_full(fifo_full));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  function automatic logic [11:0] addr_of(input int g);
    return {ofsb_pkg::IDX_FLAGS_CH1_32 + 10'(g), 2'h0};
  endfunction

  function automatic logic [31:0] sum_exp();
    logic [31:0] s;
    s = 32'h0;
    for (int g = 0; g < 4; g++) s[g] = |exp_w[g];
    return s;
  endfunction

  // request held until pready is sampled high; pready must come on the first access edge, zero wait states
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    `CHK("pready_wait", 1, n)
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one cycle of fifo strobes; clk_en low means the event must not be taken
  task automatic evt(input logic [127:0] w, input logic [127:0] f, input logic en);
    @(posedge pclk);
    fifo_wr <= w;
    fifo_full <= f;
    clk_en <= en;
    @(posedge pclk);
    if (en) for (int g = 0; g < 4; g++) exp_w[g] |= w[32*g +: 32] & f[32*g +: 32];
    fifo_wr <= '0;
    fifo_full <= '0;
    clk_en <= 1'b1;
  endtask

  task automatic clr(input int g);
    apb(1'b1, addr_of(g), xs(), rd, err);
    exp_w[g] = 32'h0;
    `CHK("clr_err", 1'b0, err)
  endtask

  task automatic check_all();
    for (int g = 0; g < 4; g++) begin
      apb(1'b0, addr_of(g), 32'h0, rd, err);
      `CHK("flags", exp_w[g], rd)
    end
    apb(1'b0, {ofsb_pkg::IDX_SUMMARY, 2'h0}, 32'h0, rd, err);
    `CHK("summary", sum_exp(), rd)
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    conclude();
  end

  initial begin
    rng = 32'h55;
    {psel, penable, pwrite, paddr, pwdata, fifo_wr, fifo_full} = '0;
    presetn = 1'b1;
    clk_en = 1'b1;
    failures = 0;
    n_checks = 0;
    foreach (exp_w[g]) exp_w[g] = 32'h0;
    // a real falling edge on reset, whichever process starts first at time zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    done("reset");
    foreach (chans[i]) begin
      evt(128'h1 << (chans[i] - 1), 128'h1 << (chans[i] - 1), 1'b1);
      apb(1'b0, addr_of((chans[i] - 1) / 32), 32'h0, rd, err);
      `CHK("map", 32'h1 << ((chans[i] - 1) % 32), rd)
      clr((chans[i] - 1) / 32);
      check_all();
    end
    done("mapping");
    // write into a fifo with room, then an overflow while frozen: neither may set
    evt(128'h8, 128'h0, 1'b1);
    evt(128'h8, 128'h8, 1'b0);
    check_all();
    evt(128'h8, 128'h8, 1'b1);
    repeat (5) @(posedge pclk);
    check_all();
    done("sticky");
    apb(1'b0, 12'h360, 32'h0, rd, err);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_rd", 32'h0, rd)
    apb(1'b0, 12'h369, 32'h0, rd, err);
    `CHK("unaligned_err", 1'b1, err)
    apb(1'b1, 12'h378, 32'hFFFFFFFF, rd, err);
    `CHK("unmapped_wr_err", 1'b1, err)
    apb(1'b1, {ofsb_pkg::IDX_SUMMARY, 2'h0}, 32'hFFFFFFFF, rd, err);
    `CHK("summary_wr_err", 1'b0, err)
    check_all();
    done("refusals");
    // channel 6 overflows at the very edge that clears word 0: the set must win
    fork
      clr(0);
      begin
        repeat (2) @(posedge pclk);
        fifo_wr <= 128'h20;
        fifo_full <= 128'h20;
        @(posedge pclk);
        fifo_wr <= '0;
        fifo_full <= '0;
      end
    join
    exp_w[0] = 32'h20;
    check_all();
    done("set_wins");
    // dense overflows saturate quickly, so a random word is cleared about half the time
    repeat (40) begin
      evt({xs(), xs(), xs(), xs()}, {xs() & xs(), xs() & xs(), xs() & xs(), xs() & xs()},
          xs() > 32'h3FFFFFFF);
      if (xs() < 32'h80000000) clr(int'(xs() & 32'h3));
      check_all();
    end
    done("random");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (exp_w[g]) exp_w[g] = 32'h0;
    check_all();
    done("second_reset");
    conclude();
  end
endmodule // ofsb_overflow_bank_tb

`default_nettype wire
